// File: hw/pwg_top.sv
// Purpose: control, configuration and event logic of a 10-bit pwm
//          generator, registers reached over avalon-mm
// Assumes: trigger and stop pins are asynchronous, single clock fx
// Notes: one access takes two cycles; pin 3 of the sync vector is the
//        trigger, pins 2..0 the halt pins
//
// The Avalon-MM slave port was chosen for this implementation.
module pwg_top
	import pwg_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sync_restart_pin,
	input wire logic [2:0] external_halt_pin,
	output logic pwm_output,
	output logic irq
);
	import pwg_pkg::*;
`include "pwg_map.svh"

	// ==========================================================
	// decoding helpers
	function automatic pwg_reg_t reg_of(input logic [15:0] a);
		pwg_reg_t r;
		r = PWG_R_NONE;
		if (a[1:0] == 2'h0) begin
			case (a[15:2])
				`PWG_IDX_IRQ_EN: r = PWG_R_IRQ_EN;
				`PWG_IDX_FLAGS: r = PWG_R_FLAGS;
				`PWG_IDX_DELAY: r = PWG_R_DELAY;
				`PWG_IDX_FILTER: r = PWG_R_FILTER;
				`PWG_IDX_MODE: r = PWG_R_MODE;
				`PWG_IDX_STOP: r = PWG_R_STOP;
				`PWG_IDX_DUTY_A_LO: r = PWG_R_DA_LO;
				`PWG_IDX_DUTY_A_HI: r = PWG_R_DA_HI;
				`PWG_IDX_DUTY_B_LO: r = PWG_R_DB_LO;
				`PWG_IDX_DUTY_B_HI: r = PWG_R_DB_HI;
				`PWG_IDX_CNT_LO: r = PWG_R_CNT_LO;
				`PWG_IDX_CNT_HI: r = PWG_R_CNT_HI;
				default: r = PWG_R_NONE;
			endcase
		end
		return r;
	endfunction

	// divider tap: code 7 ticks every cycle, code 0 every 128th
	function automatic logic tick_of(input logic [6:0] d,
		input logic [2:0] sel);
		logic [6:0] mask;
		mask = 7'h7F >> sel;
		return (d & mask) == mask;
	endfunction

	pwg_state_t s;
	pwg_state_t n;
	logic [3:0] fall;
	logic tick;
	logic acc;
	logic wr;
	logic [7:0] wd;
	pwg_reg_t sel_r;
	logic sync_restart_pin_ok;
	logic shot;
	logic emg;
	logic [3:0] ev;
	logic [1:0] code;

	// ==========================================================
	// falling edge detect on synchronised pins
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
			assign fall[gi] = s.prev[gi] & ~s.sync_b[gi];
		end
	endgenerate

	// ==========================================================
	// bus answer: first cycle waits, second cycle completes
	assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
	assign avs_readdata = {24'h000000, s.rdata};
	assign pwm_output = s.out;
	assign irq = |(s.flg & s.ien);

	// ==========================================================
	// next state
	always_comb begin
		n = s;
		ev = 4'h0;
		shot = 1'b0;
		emg = 1'b0;
		sync_restart_pin_ok = 1'b0;
		code = 2'h0;
		acc = (avs_read | avs_write) & ~s.ack;
		wr = s.ack & avs_write & avs_byteenable[0];
		wd = avs_writedata[7:0];
		sel_r = reg_of(avs_address);
		tick = tick_of(s.div, s.psel);
		n.ack = acc;
		n.div = s.div + 7'h01;

		// pin synchronisers, first stage read only by second
		n.sync_a = {sync_restart_pin, external_halt_pin};
		n.sync_b = s.sync_a;
		n.prev = s.sync_b;

		// read data captured in the waiting cycle
		if (acc) begin
			case (sel_r)
				PWG_R_IRQ_EN: n.rdata = {4'h0, s.ien};
				PWG_R_FLAGS: n.rdata = {4'h0, s.flg};
				PWG_R_DELAY: n.rdata = s.dly;
				PWG_R_FILTER: n.rdata = s.nfl;
				PWG_R_MODE: n.rdata = {s.psel, s.pol, s.mode, s.tsel};
				PWG_R_STOP: n.rdata = {s.stop_sel, s.cc, s.en};
				PWG_R_DA_LO: n.rdata = s.duty_a[7:0];
				PWG_R_DA_HI: n.rdata = {6'h00, s.duty_a[9:8]};
				PWG_R_DB_LO: n.rdata = s.duty_b[7:0];
				PWG_R_DB_HI: n.rdata = {6'h00, s.duty_b[9:8]};
				PWG_R_CNT_LO: n.rdata = s.cnt[7:0];
				PWG_R_CNT_HI: n.rdata = {6'h00, s.cnt[9:8]};
				default: n.rdata = 8'h00;
			endcase
		end

		// trigger noise filter: pin must stay low nfl cycles of fx
		if (s.nfl == 8'h00) begin
			sync_restart_pin_ok = fall[3];
			n.farm = 1'b0;
		end else if (fall[3]) begin
			n.farm = 1'b1;
			n.fcnt = 8'h01;
		end else if (s.farm) begin
			if (s.sync_b[3]) begin
				n.farm = 1'b0;
			end else if (s.fcnt >= s.nfl) begin
				sync_restart_pin_ok = 1'b1;
				n.farm = 1'b0;
			end else begin
				n.fcnt = s.fcnt + 8'h01;
			end
		end

		// counter clear bit drops one cycle after it acted
		if (s.cc) begin
			n.cc = 1'b0;
		end

		// running generator
		if (s.en && tick) begin
			if (s.st == PWG_DELAY) begin
				if (s.dcnt == 8'h00) begin
					n.st = PWG_RUN;
					n.cnt = 10'h000;
					n.out = ~s.pol;
				end else begin
					n.dcnt = s.dcnt - 8'h01;
				end
			end else if (s.st == PWG_RUN) begin
				if (s.cnt == `PWG_CNT_TOP) begin
					ev[`PWG_BIT_OVF] = 1'b1;
					n.cnt = 10'h000;
					n.out = ~s.pol;
					if (s.hold) begin
						n.duty_a = s.duty_b;
						n.hold = 1'b0;
					end
					if (!s.mode[1]) begin
						n.en = 1'b0;
						n.st = PWG_IDLE;
					end
				end else begin
					n.cnt = s.cnt + 10'h001;
					if (s.cnt + 10'h001 == s.duty_a) begin
						n.out = ~s.out;
					end
				end
			end
		end

		// register writes, completing at the edge of the ack cycle
		if (wr) begin
			case (sel_r)
				PWG_R_IRQ_EN: n.ien = wd[3:0];
				PWG_R_FLAGS: n.flg = s.flg & wd[3:0];
				PWG_R_DELAY: n.dly = wd;
				PWG_R_FILTER: n.nfl = wd;
				PWG_R_MODE: begin
					n.psel = wd[7:5];
					n.pol = wd[4];
					n.mode = wd[3:2];
					n.tsel = wd[1:0];
				end
				PWG_R_STOP: begin
					n.stop_sel = wd[7:2];
					if (wd[1]) begin
						n.cc = 1'b1;
						n.cnt = 10'h000;
					end
					n.en = wd[0];
					if (wd[0] && !s.en) begin
						n.cnt = 10'h000;
						n.st = PWG_RUN;
						n.out = ~n.pol;
						n.hold = 1'b0;
					end
				end
				PWG_R_DA_LO: n.duty_a[7:0] = wd;
				PWG_R_DA_HI: n.duty_a[9:8] = wd[1:0];
				PWG_R_DB_LO: n.duty_b[7:0] = wd;
				PWG_R_DB_HI: n.duty_b[9:8] = wd[1:0];
				default: n.ien = n.ien;
			endcase
		end

		// trigger restart
		if (sync_restart_pin_ok && s.tsel[1]) begin
			ev[`PWG_BIT_SYNC_RESTART_PIN] = 1'b1;
			// enabling is refused while an emergency is pending
			if (s.mode == 2'b01 && !s.flg[`PWG_BIT_EMG]) begin
				n.en = 1'b1;
			end
			if (n.en) begin
				n.cnt = 10'h000;
				if (s.tsel[0]) begin
					n.st = PWG_DELAY;
					n.dcnt = s.dly;
					n.out = s.pol;
				end else begin
					n.st = PWG_RUN;
					n.out = ~s.pol;
				end
			end
		end

		// stop pins
		for (int i = 0; i < 3; i++) begin
			code = s.stop_sel[2 * i +: 2];
			if (fall[i]) begin
				case (code)
					`PWG_STOP_SHOT: shot = 1'b1;
					`PWG_STOP_EMG: emg = 1'b1;
					default: shot = shot;
				endcase
			end
		end
		if (shot && n.en) begin
			n.hold = 1'b1;
			ev[`PWG_BIT_SHOT] = 1'b1;
		end
		if (emg) begin
			n.en = 1'b0;
			ev[`PWG_BIT_EMG] = 1'b1;
		end

		// hardware set wins over a software clear in the same cycle
		n.flg = n.flg | ev;

		// output rests at polarity level when held or disabled
		if (!n.en) begin
			n.st = PWG_IDLE;
			n.hold = 1'b0;
			n.out = n.pol;
		end else if (n.hold) begin
			n.out = n.pol;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.nfl <= `PWG_RST_FILTER;
			s.duty_a <= `PWG_RST_DUTY_A;
			s.duty_b <= `PWG_RST_DUTY_B;
			s.st <= PWG_IDLE;
		end else begin
			s <= n;
		end
	end

endmodule

// File: pkg/pwg_map.svh
// Purpose: register indexes, field positions and reset values of the
//          10-bit pwm generator
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef PWG_MAP_SVH
`define PWG_MAP_SVH

// ==========================================================
// register indexes (byte address = index * 4)
`define PWG_IDX_IRQ_EN 14'h103E
`define PWG_IDX_FLAGS 14'h103F
`define PWG_IDX_DELAY 14'h1066
`define PWG_IDX_FILTER 14'h1067
`define PWG_IDX_MODE 14'h1078
`define PWG_IDX_STOP 14'h1079
`define PWG_IDX_DUTY_A_LO 14'h107A
`define PWG_IDX_DUTY_A_HI 14'h107B
`define PWG_IDX_DUTY_B_LO 14'h107C
`define PWG_IDX_DUTY_B_HI 14'h107D
`define PWG_IDX_CNT_LO 14'h107E
`define PWG_IDX_CNT_HI 14'h107F

// ==========================================================
// reset values and counter top
`define PWG_RST_FILTER 8'h0F
`define PWG_RST_DUTY_A 10'h3FF
`define PWG_RST_DUTY_B 10'h000
`define PWG_CNT_TOP 10'h3FF

// ==========================================================
// flag and enable bit positions
`define PWG_BIT_OVF 3
`define PWG_BIT_EMG 2
`define PWG_BIT_SHOT 1
`define PWG_BIT_SYNC_RESTART_PIN 0

// ==========================================================
// stop pin selector codes
`define PWG_STOP_OFF 2'h0
`define PWG_STOP_SHOT 2'h1
`define PWG_STOP_EMG 2'h2

`endif

// File: pkg/pwg_pkg.sv
// Purpose: types of the 10-bit pwm generator
// Assumes: nothing
// Notes: the whole state of the block is one packed struct
package pwg_pkg;

	typedef enum logic [1:0] {
		PWG_IDLE = 2'b00,
		PWG_RUN = 2'b01,
		PWG_DELAY = 2'b10
	} pwg_run_t;

	typedef enum logic [3:0] {
		PWG_R_NONE = 4'b0000,
		PWG_R_IRQ_EN = 4'b0001,
		PWG_R_FLAGS = 4'b0010,
		PWG_R_DELAY = 4'b0011,
		PWG_R_FILTER = 4'b0100,
		PWG_R_MODE = 4'b0101,
		PWG_R_STOP = 4'b0110,
		PWG_R_DA_LO = 4'b0111,
		PWG_R_DA_HI = 4'b1000,
		PWG_R_DB_LO = 4'b1001,
		PWG_R_DB_HI = 4'b1010,
		PWG_R_CNT_LO = 4'b1011,
		PWG_R_CNT_HI = 4'b1100
	} pwg_reg_t;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic en;
		logic cc;
		logic pol;
		logic [1:0] mode;
		logic [1:0] tsel;
		logic [2:0] psel;
		logic [5:0] stop_sel;
		logic [7:0] dly;
		logic [7:0] nfl;
		logic [3:0] ien;
		logic [3:0] flg;
		logic [9:0] duty_a;
		logic [9:0] duty_b;
		logic [9:0] cnt;
		logic [6:0] div;
		logic out;
		logic hold;
		pwg_run_t st;
		logic [7:0] dcnt;
		logic [7:0] fcnt;
		logic farm;
		logic [3:0] sync_a;
		logic [3:0] sync_b;
		logic [3:0] prev;
	} pwg_state_t;

endpackage

// File: verification/pwg_properties.sv
// Purpose: port checks of pwg_top
// Assumes: byte address is register index times four
// Notes: bound to pwg_top below
`include "pwg_map.svh"
module pwg_properties (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq
);
	// ==========================================
	// helpers
	logic rq;
	logic [13:0] ix;
	assign rq = avs_read | avs_write;
	assign ix = avs_address[15:2];
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence s_new;
		rq && !$past(rq);
	endsequence
	sequence s_rd;
		avs_read && !avs_waitrequest;
	endsequence
	// ==========================================
	// properties
	property p_wait;
		s_new |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("wait cycle");
	property p_idle;
		!rq |-> !avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("idle wait");
	property p_hi;
		s_rd |-> avs_readdata[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper bits");
	property p_unmap;
		s_rd ##0 ix == 14'h0 |-> avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_ien;
		s_rd ##0 ix == `PWG_IDX_IRQ_EN |-> avs_readdata[7:4] == 4'h0;
	endproperty
	a_ien: assert property (p_ien) else $error("enables");
	property p_flg;
		s_rd ##0 ix == `PWG_IDX_FLAGS |-> avs_readdata[7:4] == 4'h0;
	endproperty
	a_flg: assert property (p_flg) else $error("flags");
	property p_cnt;
		s_rd ##0 ix == `PWG_IDX_CNT_HI |-> avs_readdata[7:2] == 6'h0;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count");
	property p_mask;
		s_rd ##0 (ix == `PWG_IDX_IRQ_EN && avs_readdata[3:0] == 4'h0)
			|-> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked");
	property p_off;
		avs_write && !avs_waitrequest && ix == `PWG_IDX_IRQ_EN &&
			avs_byteenable[0] && avs_writedata[3:0] == 4'h0 |-> ##2 !irq;
	endproperty
	a_off: assert property (p_off) else $error("irq off");
endmodule
bind pwg_top pwg_properties u_chk (.clock(clock), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq));

// File: verification/pwg_pins.sv
// Purpose: trigger and halt pin sources
// Assumes: pins idle high, called just after a rising edge
// Notes: m bit 3 is the trigger, bits 2..0 the halt pins
module pwg_pins (
	input wire logic clock,
	output logic sync_restart_pin,
	output logic [2:0] external_halt_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sync_restart_pin = 1'b1;
		external_halt_pin = 3'h7;
	end
	// width w lets a pulse be short enough for the filter to reject
	task pulse(input logic [3:0] m, input int w);
		repeat (w) begin
			sync_restart_pin <= ~m[3];
			external_halt_pin <= ~m[2:0];
			@(posedge clock);
		end
		sync_restart_pin <= 1'b1;
		external_halt_pin <= 3'h7;
		@(posedge clock);
	endtask
endmodule

// File: verification/pwg_top_bench.sv
// Purpose: self-checking bench of pwg_top
// Assumes: register index times four is the byte address
// Notes: read/write registers modelled in an associative array
`include "pwg_map.svh"
module pwg_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [13:0] STP = `PWG_IDX_STOP;
	localparam logic [13:0] MOD = `PWG_IDX_MODE;
	localparam logic [13:0] FLG = `PWG_IDX_FLAGS;
	localparam logic [13:0] CNT = `PWG_IDX_CNT_LO;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] avs_address = 16'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, pwm_output, irq, sync_restart_pin;
	logic [2:0] external_halt_pin;
	int errors = 0;
	int comparisons = 0;
	logic [7:0] m [int];
	logic [7:0] d, c;
	always #2.5 clock = ~clock;
	pwg_top dut (.clock(clock), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.sync_restart_pin(sync_restart_pin),
		.external_halt_pin(external_halt_pin),
		.pwm_output(pwm_output), .irq(irq));
	pwg_pins pins (.clock(clock), .sync_restart_pin(sync_restart_pin),
		.external_halt_pin(external_halt_pin));
	// ==========================================
	// tasks
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [13:0] i, input logic [7:0] v);
		int k;
		k = 0;
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h0, v};
		@(posedge clock);
		while (avs_waitrequest !== 1'b0 && k < 50) begin
			@(posedge clock);
			k++;
		end
		if (k == 50) begin
			errors++;
			end_of_test();
		end
		d = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task wr(input logic [13:0] i, input logic [7:0] v);
		bus(1'b1, i, v);
		m[i] = (i == `PWG_IDX_IRQ_EN) ? (v & 8'h0F) : v;
	endtask
	task rc(input logic [13:0] i);
		bus(1'b0, i, 8'h0);
		chk("reg", m[i], d);
	endtask
	// ==========================================
	// tests
	initial begin
		void'($urandom(32'h3AE0));
		m[`PWG_IDX_IRQ_EN] = 8'h0;
		m[FLG] = 8'h0;
		m[`PWG_IDX_DELAY] = 8'h0;
		m[`PWG_IDX_FILTER] = `PWG_RST_FILTER;
		m[MOD] = 8'h0;
		m[STP] = 8'h0;
		m[CNT] = 8'h0;
		m[0] = 8'h0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		chk("rest", 8'h0, 8'(pwm_output));
		foreach (m[i]) rc(14'(i));
		$display("reset values done");
		wr(`PWG_IDX_DELAY, 8'($urandom));
		wr(`PWG_IDX_FILTER, 8'($urandom));
		wr(`PWG_IDX_IRQ_EN, 8'($urandom));
		// a write without byte lane 0 and a write to the counter are lost
		avs_byteenable <= 4'hE;
		bus(1'b1, `PWG_IDX_DELAY, 8'h5A);
		avs_byteenable <= 4'hF;
		bus(1'b1, CNT, 8'hA5);
		bus(1'b1, 14'h0, 8'hFF);
		foreach (m[i]) rc(14'(i));
		$display("access done");
		for (int p = 0; p < 8; p++) begin
			wr(MOD, {3'(p), 5'h08});
			bus(1'b1, STP, 8'h01);
			bus(1'b0, CNT, 8'h0);
			c = d;
			// read captures land exactly 128 clocks apart
			repeat (125) @(posedge clock);
			bus(1'b0, CNT, 8'h0);
			chk("step", 8'(128 >> (7 - p)), d - c);
		end
		$display("prescale done");
		wr(`PWG_IDX_IRQ_EN, 8'h08);
		wr(MOD, 8'hE8);
		repeat (1100) @(posedge clock);
		chk("irq", 8'h1, 8'(irq));
		bus(1'b1, STP, 8'h00);
		bus(1'b0, FLG, 8'h0);
		chk("ovf", 8'h08, d);
		bus(1'b1, FLG, 8'hF7);
		bus(1'b0, FLG, 8'h0);
		chk("clear", 8'h00, d);
		chk("irq", 8'h0, 8'(irq));
		wr(MOD, 8'hE0);
		bus(1'b1, STP, 8'h01);
		repeat (1100) @(posedge clock);
		bus(1'b0, STP, 8'h0);
		chk("shot end", 8'h00, d);
		wr(MOD, 8'h08);
		bus(1'b1, STP, 8'h01);
		repeat (700) @(posedge clock);
		bus(1'b0, CNT, 8'h0);
		chk("run", 8'h1, 8'(d >= 2));
		bus(1'b1, STP, 8'h03);
		bus(1'b0, STP, 8'h0);
		chk("cc", 8'h01, d);
		bus(1'b0, CNT, 8'h0);
		chk("clr", 8'h1, 8'(d < 2));
		$display("modes done");
		wr(MOD, 8'hF8);
		bus(1'b1, STP, 8'h39);
		pins.pulse(4'h6, 3);
		repeat (8) @(posedge clock);
		bus(1'b0, STP, 8'h0);
		chk("ignored", 8'h39, d);
		pins.pulse(4'h1, 3);
		repeat (8) @(posedge clock);
		bus(1'b0, STP, 8'h0);
		chk("emg", 8'h38, d);
		chk("rest", 8'h1, 8'(pwm_output));
		bus(1'b0, FLG, 8'h0);
		chk("emgf", 8'h04, d & 8'h04);
		bus(1'b1, FLG, 8'h00);
		wr(MOD, 8'h88);
		bus(1'b1, `PWG_IDX_DUTY_B_LO, 8'h55);
		bus(1'b1, STP, 8'h41);
		repeat (2) @(posedge clock);
		chk("start", 8'h1, 8'(pwm_output));
		pins.pulse(4'h4, 2);
		repeat (6) @(posedge clock);
		for (int j = 0; j < 50; j++) begin
			@(posedge clock);
			chk("held", 8'h0, 8'(pwm_output));
		end
		repeat (8400) @(posedge clock);
		bus(1'b0, `PWG_IDX_DUTY_A_LO, 8'h0);
		chk("duty", 8'h55, d);
		bus(1'b0, FLG, 8'h0);
		chk("shotf", 8'h02, d & 8'h02);
		$display("stops done");
		bus(1'b1, STP, 8'h00);
		wr(`PWG_IDX_FILTER, 8'h00);
		wr(MOD, 8'hE6);
		pins.pulse(4'h8, 2);
		repeat (6) @(posedge clock);
		bus(1'b0, STP, 8'h0);
		chk("auto", 8'h01, d & 8'h01);
		bus(1'b0, FLG, 8'h0);
		chk("trgf", 8'h01, d & 8'h01);
		repeat (1100) @(posedge clock);
		wr(`PWG_IDX_FILTER, 8'h20);
		pins.pulse(4'h8, 8);
		repeat (40) @(posedge clock);
		bus(1'b0, STP, 8'h0);
		chk("filter", 8'h00, d & 8'h01);
		wr(MOD, 8'hE4);
		pins.pulse(4'h8, 60);
		bus(1'b0, STP, 8'h0);
		chk("sync_restart_pin off", 8'h00, d & 8'h01);
		wr(`PWG_IDX_DELAY, 8'h03);
		wr(MOD, 8'hE7);
		pins.pulse(4'h8, 60);
		repeat (8) @(posedge clock);
		bus(1'b0, STP, 8'h0);
		chk("delayed", 8'h01, d & 8'h01);
		// all enables off must mask every pending flag
		wr(`PWG_IDX_IRQ_EN, 8'h00);
		rc(`PWG_IDX_IRQ_EN);
		chk("irq masked", 8'h0, 8'(irq));
		$display("trigger done");
		end_of_test();
	end
endmodule
